// File: idss_top.sv
// Drive chip selects, latch enables, bit 7 steering and shared pin selection.
// Assumes host strobes and pins are asynchronous to sys_clk_i and are synchronised here.
`timescale 1ns/1ns
// Notes on behaviour
// - Primary base selects command block 1f0-1f7
// - Secondary base selects command block 170-177
// - Primary base selects control block 3f6-3f7
// - Secondary base selects control block 376-377
// - Disabled interface holds both selects inactive
// - Control bit 1 picks DMA acknowledge role
// - DMA acknowledge role forces wide cycle
// - Bit 7 driven in decoded ranges
// - Bit 7 floats at 3f7 and 377
// - High latch only on wide cycles
// - Low latch on every drive access
module idss_top import idss_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [9:0] host_addr_i,
	input wire logic host_rd_n_i,
	input wire logic host_wr_n_i,
	input wire logic host_aen_i,
	input wire logic at_mode_i,
	input wire logic ide_enable_i,
	input wire logic use_secondary_i,
	input wire logic [7:0] function_control_reg_i,
	input wire logic shared_pin_n_i,
	input wire logic host_d7_i,
	input wire logic drive_data_bit7_i,
	output logic drive_cmd_block_select_n_o,
	output logic drive_ctl_block_select_n_o,
	output logic high_byte_latch_enable_n_o,
	output logic low_byte_latch_enable_n_o,
	output logic drive_dma_ack_in_n_o,
	output logic wide_cycle_indication_n_o,
	output logic drive_data_bit7_o,
	output logic drive_data_bit7_oe_o,
	output logic host_d7_o,
	output logic host_d7_oe_o
);
	// Width of the pin word and its idle levels while reset is held
	// Strobes, address enable and the shared pin idle high; bit 7 levels idle low
	// A high address enable keeps the decoder quiet until real pin levels arrive
	localparam int SYNC_W = 16;
	localparam logic [SYNC_W-1:0] SYNC_RST = 16'hfffc;

	// Raw pin word: address, strobes, enable, shared pin, then both bit 7 levels
	logic [SYNC_W-1:0] pin_raw;
	logic [SYNC_W-1:0] pin_sync;
	assign pin_raw = {host_addr_i, host_rd_n_i, host_wr_n_i, host_aen_i, shared_pin_n_i,
		host_d7_i, drive_data_bit7_i};

	// Two flops per pin bit; only the second flop feeds any logic
	// Bits cross one by one, so a changing address may show a mixed value for a cycle;
	// the selects are levels and settle one cycle later, which the host bus tolerates
	for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
		logic [1:0] stage_q;
		always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				stage_q <= {2{SYNC_RST[i]}};
			end else begin
				stage_q <= {stage_q[0], pin_raw[i]};
			end
		end
		assign pin_sync[i] = stage_q[1];
	end

	// Synchronised host cycle and pin levels
	idss_host_s host;
	logic pin_n;
	logic hd7;
	logic dd7;
	assign host.addr = pin_sync[15:6];
	assign host.rd = ~pin_sync[5]; // Strobes are active low on the pins
	assign host.wr = ~pin_sync[4];
	assign host.aen = pin_sync[3];
	assign pin_n = pin_sync[2];
	assign hd7 = pin_sync[1];
	assign dd7 = pin_sync[0];

	// Address match against a masked base
	function automatic logic hit(input logic [9:0] a, input logic [9:0] base,
		input logic [9:0] mask);
		hit = ((a & mask) == base);
	endfunction

	logic live;
	logic cmd_hit;
	logic ctl_hit;
	logic cycle;
	logic dma_role;
	logic wide_n;
	logic alt_reg;
	assign live = at_mode_i & ide_enable_i & ~host.aen;
	assign cmd_hit = live & (use_secondary_i ? hit(host.addr, CMD_SEC_BASE, CMD_MASK)
		: hit(host.addr, CMD_PRI_BASE, CMD_MASK));
	assign ctl_hit = live & (use_secondary_i ? hit(host.addr, CTL_SEC_BASE, CTL_MASK)
		: hit(host.addr, CTL_PRI_BASE, CTL_MASK));
	assign cycle = host.rd | host.wr;
	assign dma_role = function_control_reg_i[FCR_DMA_ACK_BIT];
	assign wide_n = dma_role ? 1'b0 : pin_n;
	// 3f7 or 377 floats bit 7
	assign alt_reg = ((host.addr & ALT_STATUS_BIT) != 10'h000);

	// command block select, off when disabled
	// Selects follow the decoded address and enables, not the strobes, so the drive sees them before the strobe
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			drive_cmd_block_select_n_o <= 1'b1;
		end else begin
			drive_cmd_block_select_n_o <= ~cmd_hit;
		end
	end

	// control block select, off when disabled
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			drive_ctl_block_select_n_o <= 1'b1;
		end else begin
			drive_ctl_block_select_n_o <= ~ctl_hit;
		end
	end

	// high latch, wide cycles only
	// The wide indication comes late from the drive; the latch opens once it settles
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			high_byte_latch_enable_n_o <= 1'b1;
		end else begin
			high_byte_latch_enable_n_o <= ~((cmd_hit | ctl_hit) & cycle & ~wide_n);
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			low_byte_latch_enable_n_o <= 1'b1;
		end else begin
			low_byte_latch_enable_n_o <= ~((cmd_hit | ctl_hit) & cycle);
		end
	end

	// acknowledge role of the shared pin
	// Outside the acknowledge role the pin never reaches this output
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			drive_dma_ack_in_n_o <= 1'b1;
		end else begin
			drive_dma_ack_in_n_o <= dma_role ? pin_n : 1'b1;
		end
	end

	// wide cycle role, forced active in acknowledge role
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wide_cycle_indication_n_o <= 1'b1;
		end else begin
			wide_cycle_indication_n_o <= wide_n;
		end
	end

	// Bit 7 is steered only for a strobed cycle in the decoded ranges
	// The alternate status slot of the control block is left floating
	logic steer;
	assign steer = (cmd_hit | (ctl_hit & ~alt_reg)) & cycle;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			drive_data_bit7_o <= 1'b0;
		end else begin
			drive_data_bit7_o <= hd7;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			drive_data_bit7_oe_o <= 1'b0;
		end else begin
			drive_data_bit7_oe_o <= steer & host.wr;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			host_d7_o <= 1'b0;
		end else begin
			host_d7_o <= dd7;
		end
	end

	// host side enable on reads
	// A cycle showing both strobes is treated as a write so the two sides never fight
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			host_d7_oe_o <= 1'b0;
		end else begin
			host_d7_oe_o <= steer & host.rd & ~host.wr;
		end
	end
endmodule // idss_top

// File: idss_pkg.sv
// Package for the drive select and data bit 7 steering block.
// Assumes a 10-bit host I/O address and a single 100 MHz system clock.
package idss_pkg;
	localparam logic [9:0] CMD_PRI_BASE = 10'h1f0;
	localparam logic [9:0] CMD_SEC_BASE = 10'h170;
	localparam logic [9:0] CTL_PRI_BASE = 10'h3f6;
	localparam logic [9:0] CTL_SEC_BASE = 10'h376;
	localparam logic [9:0] CMD_MASK = 10'h3f8;
	localparam logic [9:0] CTL_MASK = 10'h3fe;
	localparam logic [9:0] ALT_STATUS_BIT = 10'h001;
	localparam int FCR_DMA_ACK_BIT = 1;
	localparam logic [7:0] FCR_RESET = 8'h00;

	// Host bus cycle as seen by the decoder
	typedef struct packed {
		logic [9:0] addr;
		logic rd;
		logic wr;
		logic aen;
	} idss_host_s;
endpackage

// File: idss_chk.sv
// Checker for the drive selects, pin roles and bit 7 steering.
// Bound to idss_top; watches its ports only.
`timescale 1ns/1ns
module idss_chk (
	input logic sys_clk_i, rst_n_i, host_wr_n_i, host_aen_i, at_mode_i, ide_enable_i,
	input logic use_secondary_i, drive_cmd_block_select_n_o, drive_ctl_block_select_n_o,
	input logic low_byte_latch_enable_n_o, drive_dma_ack_in_n_o, wide_cycle_indication_n_o,
	input logic drive_data_bit7_oe_o, host_d7_oe_o,
	input logic [9:0] host_addr_i,
	input logic [7:0] function_control_reg_i
);
	logic on, cp, tp;
	// Enabled decode: base bit, then command or control range
	assign on = at_mode_i & ide_enable_i & ~host_aen_i & (host_addr_i[7] ^ use_secondary_i);
	assign cp = on & (host_addr_i[9:8] == 2'h1) & (host_addr_i[6:3] == 4'he);
	assign tp = on & (host_addr_i[9:8] == 2'h3) & (host_addr_i[6:1] == 6'h3b);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	cmd_sel_a: assert property (cp [*5] |-> !drive_cmd_block_select_n_o)
		else $error("no cmd select");
	ctl_sel_a: assert property (tp [*5] |-> !drive_ctl_block_select_n_o)
		else $error("no ctl select");
	off_quiet_a: assert property (
		(!ide_enable_i) [*2] |-> drive_cmd_block_select_n_o && drive_ctl_block_select_n_o)
		else $error("select while off");
	ack_role_a: assert property (
		(!function_control_reg_i[1]) [*2] |-> drive_dma_ack_in_n_o) else $error("ack leak");
	wide_force_a: assert property (
		function_control_reg_i[1] [*2] |-> !wide_cycle_indication_n_o) else $error("no wide");
	bit7_float_a: assert property (
		(tp && host_addr_i[0]) [*5] |-> !(drive_data_bit7_oe_o | host_d7_oe_o)) else $error("driven");
	wr_dir_a: assert property (
		(cp && !host_wr_n_i) [*5] |-> drive_data_bit7_oe_o && !host_d7_oe_o
		&& !low_byte_latch_enable_n_o) else $error("write path");
	ctl_wr_a: assert property (
		(tp && !host_addr_i[0] && !host_wr_n_i) [*5] |-> drive_data_bit7_oe_o) else $error("ctl bit7");
	cover property (cp && !host_wr_n_i);
	cover property (tp && host_addr_i[0]);
	cover property (function_control_reg_i[1] && cp);
endmodule // idss_chk
bind idss_top idss_chk u_chk (.*);

// File: idss_drive_model.sv
// Drive side model: wide-cycle pin and bit 7 returned on reads.
// Takes the block's combined active-low select and the host read strobe.
`timescale 1ns/1ns
module idss_drive_model (
	input logic clk_i, sel_n_i, rd_n_i, wide_i, d7_i,
	output logic pin_n_o,
	output logic d7_o = 1'b0
);
	// Bit 7 held only while selected and read, else flips every cycle
	always @(posedge clk_i) d7_o <= (!sel_n_i && !rd_n_i) ? d7_i : !d7_o;
	// Wide-cycle pin pulled low only while selected
	assign pin_n_o = !(wide_i && !sel_n_i);
endmodule // idss_drive_model

// File: test_ide_select_and_data_steer.sv
// Testbench: a table of host cycles against a drive model.
// Drops AT mode or raises the address enable in cases with bit 7 of the index set.
`timescale 1ns/1ns
module test_ide_select_and_data_steer;
	logic sys_clk_i = 0, rst_n_i = 0, host_rd_n_i = 1, host_wr_n_i = 1, host_aen_i = 0, c, t, s, w;
	logic at_mode_i = 1, ide_enable_i = 1, use_secondary_i = 0, host_d7_i = 0, wide = 0, d7 = 0;
	logic shared_pin_n_i, drive_data_bit7_i, drive_data_bit7_o, host_d7_o, drive_data_bit7_oe_o;
	logic drive_cmd_block_select_n_o, drive_ctl_block_select_n_o, high_byte_latch_enable_n_o;
	logic low_byte_latch_enable_n_o, drive_dma_ack_in_n_o, wide_cycle_indication_n_o, host_d7_oe_o;
	logic [9:0] host_addr_i = 10'h000, a;
	logic [7:0] function_control_reg_i = 8'h00, e, o;
	logic [9:0] tbl [8] = '{10'h1f0, 10'h1f7, 10'h170, 10'h177, 10'h3f6, 10'h3f7, 10'h376, 10'h3e8};
	int num_errors = 0, checks = 0;
	// Output levels gathered for one compare
	assign o = {drive_cmd_block_select_n_o, drive_ctl_block_select_n_o, high_byte_latch_enable_n_o,
		low_byte_latch_enable_n_o, drive_dma_ack_in_n_o, wide_cycle_indication_n_o,
		drive_data_bit7_oe_o, host_d7_oe_o};
	idss_top dut (.*);
	idss_drive_model drv (.clk_i(sys_clk_i), .rd_n_i(host_rd_n_i), .wide_i(wide), .d7_i(d7),
		.sel_n_i(drive_cmd_block_select_n_o & drive_ctl_block_select_n_o),
		.pin_n_o(shared_pin_n_i), .d7_o(drive_data_bit7_i));
	// Clock at 100 MHz
	always #5 sys_clk_i = ~sys_clk_i;
	task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
		checks++;
		if (g !== x) begin
			num_errors++;
			$display("BAD %s exp %h got %h", n, x, g);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Watchdog well past the run of about 2300 cycles
	initial begin
		repeat (4000) @(posedge sys_clk_i);
		num_errors++;
		results();
	end
	// Reset, then each entry by base, strobe, pin role and enable; wide pin follows index bit 1
	initial begin
		repeat (12) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		for (int k = 0; k < 256; k++) begin
			at_mode_i <= !(k[7] && k[1]);
			host_aen_i <= k[7] && !k[1];
			a = tbl[k[2:0]];
			host_addr_i <= a;
			use_secondary_i <= k[3];
			{host_wr_n_i, host_rd_n_i} <= {!k[4], k[4]};
			function_control_reg_i <= {6'h00, k[5], 1'b0};
			ide_enable_i <= !k[6];
			{host_d7_i, d7, wide} <= {k[0], !k[0], k[1]};
			repeat (9) @(posedge sys_clk_i);
			c = !k[6] && !k[7] && a[9:3] == (k[3] ? 7'h2e : 7'h3e);
			t = !k[6] && !k[7] && a[9:1] == (k[3] ? 9'h1bb : 9'h1fb);
			s = c || (t && !a[0]);
			w = k[1] && (c || t);
			e = {!c, !t, !((c || t) && (k[5] || w)), !(c || t), !(k[5] && w), !k[5] && !w,
				k[4] && s, !k[4] && s};
			chk("outputs", e, o);
			if (s) chk("bit7", {7'h00, k[0] ^ !k[4]}, {7'h00, k[4] ? drive_data_bit7_o : host_d7_o});
			$display("case %0d done", k);
		end
		results();
	end
endmodule // test_ide_select_and_data_steer
